// ---- ifbm_pkg.sv ----
// Package: constants and types of the instruction fetch bus master port
package ifbm_pkg;

  localparam int IFBM_ADDR_W = 30;
  localparam int IFBM_LINE_WORDS = 8;
  localparam int IFBM_PAGE_LSB = 8;
  localparam logic [1:0] IFBM_SIZE_4W = 2'h1;
  localparam logic [1:0] IFBM_SIZE_8W = 2'h2;
  localparam logic [1:0] IFBM_PRIO_RST = 2'h3;
  localparam logic [1:0] IFBM_PEND_MAX = 2'h2;
  localparam int IFBM_THIRD_GAP_CYC = 2;

  typedef enum logic [0:0]
  {
    IFBM_ST_IDLE = 1'b0,
    IFBM_ST_REQ = 1'b1
  } ifbm_req_state_e;

  typedef struct packed
  {
    logic [27:0] line;
    logic eight;
    logic cacheable;
    logic touch;
    logic wide;
  } ifbm_ent_s;

  // Data transfers needed for a line, by line size and slave width
  function automatic logic [3:0] ifbm_beats(input logic eight,
                                            input logic wide);
    logic [3:0] n;
    n = eight ? 4'h8 : 4'h4;
    ifbm_beats = wide ? {1'b0, n[3:1]} : n;
  endfunction

endpackage

// ---- ifbm_beat_if.sv ----
// Interface: read data beats passed from the request tracker to the buffer
`timescale 1ns/10ps
`default_nettype none
interface ifbm_beat_if;
  import ifbm_pkg::*;
  logic start;
  logic beat;
  logic last;
  logic [2:0] slot;
  logic [63:0] data;
  ifbm_ent_s ent;

  modport trk
  (
    output start,
    output beat,
    output last,
    output slot,
    output data,
    output ent
  );
  modport fbuf
  (
    input start,
    input beat,
    input last,
    input slot,
    input data,
    input ent
  );
endinterface
`default_nettype wire

// ---- ifbm_req_track.sv ----
// Module: queue of acknowledged requests and count of their data beats
`timescale 1ns/10ps
`default_nettype none
module ifbm_req_track
(
  input wire logic clk_sys,
  input wire logic rst_n,
  input wire logic push,
  input wire ifbm_pkg::ifbm_ent_s push_ent,
  input wire logic rd_data_ack,
  input wire logic [2:0] rd_word_index,
  input wire logic [63:0] rd_data,
  output logic [1:0] pend_cnt,
  output logic done,
  ifbm_beat_if.trk bt
);
  import ifbm_pkg::*;

  ifbm_ent_s q_ff [2];
  ifbm_ent_s nxt_q [2];
  logic [1:0] cnt_ff;
  logic [1:0] nxt_cnt;
  logic [3:0] got_ff;
  logic [3:0] nxt_got;
  logic pop;

  // ---------------------------------------------------------------
  // Beat decode
  // ---------------------------------------------------------------
  always_comb
  begin
    bt.ent = q_ff[0];
    bt.data = rd_data;
    bt.slot = rd_word_index;
    bt.beat = rd_data_ack && (cnt_ff != 2'h0);
    bt.start = bt.beat && (got_ff == 4'h0);
    // Words of the head request all come before the next one
    pop = bt.beat && ((got_ff + 4'h1) ==
          ifbm_beats(q_ff[0].eight, q_ff[0].wide));
    bt.last = pop;
    done = pop;
    pend_cnt = cnt_ff;
  end

  always_comb
  begin
    nxt_q = q_ff;
    nxt_cnt = cnt_ff;
    nxt_got = pop ? 4'h0 : (bt.beat ? got_ff + 4'h1 : got_ff);
    if (pop)
    begin
      nxt_q[0] = q_ff[1];
      nxt_cnt = nxt_cnt - 2'h1;
    end
    if (push)
    begin
      nxt_q[nxt_cnt[0]] = push_ent;
      nxt_cnt = nxt_cnt + 2'h1;
    end
  end

  always_ff @(posedge clk_sys or negedge rst_n)
  begin
    if (!rst_n)
    begin
      q_ff[0] <= '0;
      q_ff[1] <= '0;
      cnt_ff <= 2'h0;
      got_ff <= 4'h0;
    end
    else
    begin
      q_ff <= nxt_q;
      cnt_ff <= nxt_cnt;
      got_ff <= nxt_got;
    end
  end
endmodule
`default_nettype wire

// ---- ifbm_fill_buf.sv ----
// Module: line fill buffer with lookup port and cache write-back
`timescale 1ns/10ps
`default_nettype none
module ifbm_fill_buf
(
  input wire logic clk_sys,
  input wire logic rst_n,
  ifbm_beat_if.fbuf bt,
  input wire logic fetch_no_allocate,
  input wire logic [29:0] lookup_addr,
  output logic lookup_hit_ff,
  output logic [31:0] lookup_word_ff,
  output logic cache_wr_ff,
  output logic [26:0] cache_wr_line_ff,
  output logic [255:0] cache_wr_data_ff
);
  import ifbm_pkg::*;

  logic [31:0] word_ff [IFBM_LINE_WORDS];
  logic [31:0] nxt_word [IFBM_LINE_WORDS];
  logic [7:0] vld_ff;
  logic [7:0] nxt_vld;
  ifbm_ent_s ent_ff;
  ifbm_ent_s nxt_ent;
  logic nxt_hit;
  logic [31:0] nxt_lword;
  logic nxt_cwr;
  logic [255:0] line_data;

  always_comb
  begin
    nxt_word = word_ff;
    nxt_vld = vld_ff;
    nxt_ent = ent_ff;
    // A new line claims the buffer and drops the old one
    if (bt.start)
    begin
      nxt_vld = 8'h00;
      nxt_ent = bt.ent;
    end
    // Data lands at the slot named by the slave
    if (bt.beat && bt.ent.wide)
    begin
      nxt_word[{bt.slot[2:1], 1'b0}] = bt.data[63:32];
      nxt_word[{bt.slot[2:1], 1'b1}] = bt.data[31:0];
      nxt_vld[{bt.slot[2:1], 1'b0}] = 1'b1;
      nxt_vld[{bt.slot[2:1], 1'b1}] = 1'b1;
    end
    else if (bt.beat)
    begin
      nxt_word[bt.slot] = bt.slot[0] ? bt.data[31:0] : bt.data[63:32];
      nxt_vld[bt.slot] = 1'b1;
    end
    // Lookups are answered from the buffer while it fills
    nxt_hit = vld_ff[lookup_addr[2:0]] && (ent_ff.eight ?
              ent_ff.line[27:1] == lookup_addr[29:3] :
              ent_ff.line == lookup_addr[29:2]);
    nxt_lword = word_ff[lookup_addr[2:0]];
    // Only a full cacheable line goes to the cache
    nxt_cwr = bt.last && bt.ent.cacheable &&
              (!fetch_no_allocate || bt.ent.touch);
    for (int i = 0; i < IFBM_LINE_WORDS; i++)
    begin
      line_data[255 - 32*i -: 32] = nxt_word[i];
    end
  end

  always_ff @(posedge clk_sys or negedge rst_n)
  begin
    if (!rst_n)
    begin
      for (int i = 0; i < IFBM_LINE_WORDS; i++)
      begin
        word_ff[i] <= 32'h0;
      end
      vld_ff <= 8'h00;
      ent_ff <= '0;
      lookup_hit_ff <= 1'b0;
      lookup_word_ff <= 32'h0;
      cache_wr_ff <= 1'b0;
      cache_wr_line_ff <= 27'h0;
      cache_wr_data_ff <= 256'h0;
    end
    else
    begin
      word_ff <= nxt_word;
      vld_ff <= nxt_vld;
      ent_ff <= nxt_ent;
      lookup_hit_ff <= nxt_hit;
      lookup_word_ff <= nxt_lword;
      cache_wr_ff <= nxt_cwr;
      cache_wr_line_ff <= nxt_cwr ? bt.ent.line[27:1] : cache_wr_line_ff;
      cache_wr_data_ff <= nxt_cwr ? line_data : cache_wr_data_ff;
    end
  end

  property p_cache_fill;
    @(posedge clk_sys) disable iff (!rst_n)
    bt.last && bt.ent.cacheable && !fetch_no_allocate |=> cache_wr_ff;
  endproperty
  a_cache_fill: assert property (p_cache_fill)
    else $error("full cacheable line not written to cache");
endmodule
`default_nettype wire

// ---- ifbm_port.sv ----
// Module: instruction fetch master port on the processor local bus
`timescale 1ns/10ps
`default_nettype none
module ifbm_port
(
  input wire logic clk_sys,
  input wire logic rst_n,
  input wire logic cpu_req_valid,
  input wire logic [29:0] cpu_req_addr,
  input wire logic cpu_req_cacheable,
  input wire logic cpu_req_user,
  input wire logic cpu_req_touch,
  input wire logic cpu_req_cancel,
  input wire logic noncache_req_size,
  input wire logic fetch_no_allocate,
  input wire logic [1:0] fetch_priority_bits,
  input wire logic pipe_en,
  input wire logic addr_ack,
  input wire logic slave_width,
  input wire logic rd_data_ack,
  input wire logic [2:0] rd_word_index,
  input wire logic [63:0] rd_data,
  input wire logic [29:0] lookup_addr,
  output logic fetch_req,
  output logic [29:0] fetch_addr,
  output logic [1:0] line_size,
  output logic cacheable_attr,
  output logic user_attr,
  output logic [1:0] req_priority,
  output logic fetch_abort,
  output logic cpu_req_taken,
  output logic cpu_req_dropped,
  output logic lookup_hit,
  output logic [31:0] lookup_word,
  output logic cache_wr,
  output logic [26:0] cache_wr_line,
  output logic [255:0] cache_wr_data
);
  import ifbm_pkg::*;

  // ---------------------------------------------------------------
  // Request state
  // ---------------------------------------------------------------
  ifbm_req_state_e st_ff;
  ifbm_req_state_e nxt_st;
  logic req_ff;
  logic nxt_req;
  logic abort_ff;
  logic nxt_abort;
  logic [29:0] addr_ff;
  logic [29:0] nxt_addr;
  logic [1:0] size_ff;
  logic [1:0] nxt_size;
  logic cache_ff;
  logic nxt_cache;
  logic user_ff;
  logic nxt_user;
  logic touch_ff;
  logic nxt_touch;
  logic [1:0] prio_ff;
  logic [1:0] nxt_prio;
  logic [1:0] prio_cfg_ff;
  logic taken_ff;
  logic nxt_taken;
  logic dropped_ff;
  logic nxt_dropped;
  logic [1:0] pend_cnt;
  logic trk_done;
  logic push;
  logic can_issue;
  logic same_page;
  logic [1:0] want_size;
  ifbm_ent_s push_ent;

  ifbm_beat_if bt ();

  // ---------------------------------------------------------------
  // Issue decision
  // ---------------------------------------------------------------
  always_comb
  begin
    want_size = (cpu_req_cacheable || noncache_req_size) ?
                IFBM_SIZE_8W : IFBM_SIZE_4W;
    same_page = addr_ff[29:IFBM_PAGE_LSB] ==
                cpu_req_addr[29:IFBM_PAGE_LSB];
    // A pipelined second request needs an eight-word line
    // in the same page as the one in flight
    can_issue = (pend_cnt == 2'h0) ||
                ((pend_cnt == 2'h1) && pipe_en && same_page &&
                 (size_ff == IFBM_SIZE_8W) &&
                 (want_size == IFBM_SIZE_8W));
    // Abort cycle's acknowledge does not start a transfer
    push = req_ff && addr_ack && !abort_ff;
    push_ent.line = addr_ff[29:2];
    push_ent.eight = size_ff == IFBM_SIZE_8W;
    push_ent.cacheable = cache_ff;
    push_ent.touch = touch_ff;
    push_ent.wide = slave_width;
  end

  always_comb
  begin
    nxt_st = st_ff;
    nxt_req = req_ff;
    nxt_abort = 1'b0;
    nxt_addr = addr_ff;
    nxt_size = size_ff;
    nxt_cache = cache_ff;
    nxt_user = user_ff;
    nxt_touch = touch_ff;
    nxt_prio = prio_ff;
    nxt_taken = 1'b0;
    nxt_dropped = 1'b0;
    case (st_ff)
      IFBM_ST_IDLE:
      begin
        // Request is always low here for at least one cycle
        if (cpu_req_valid && can_issue)
        begin
          nxt_st = IFBM_ST_REQ;
          nxt_req = 1'b1;
          nxt_addr = cpu_req_addr;
          nxt_size = want_size;
          nxt_cache = cpu_req_cacheable;
          nxt_user = cpu_req_user;
          nxt_touch = cpu_req_touch;
          nxt_prio = prio_cfg_ff;
        end
      end
      IFBM_ST_REQ:
      begin
        if (abort_ff)
        begin
          nxt_st = IFBM_ST_IDLE;
          nxt_req = 1'b0;
          nxt_dropped = 1'b1;
        end
        else if (addr_ack)
        begin
          nxt_st = IFBM_ST_IDLE;
          nxt_req = 1'b0;
          nxt_taken = 1'b1;
        end
        else if (cpu_req_cancel)
        begin
          nxt_abort = 1'b1;
        end
      end
      default:
      begin
        nxt_st = IFBM_ST_IDLE;
        nxt_req = 1'b0;
      end
    endcase
  end

  always_ff @(posedge clk_sys or negedge rst_n)
  begin
    if (!rst_n)
    begin
      st_ff <= IFBM_ST_IDLE;
      req_ff <= 1'b0;
      abort_ff <= 1'b0;
      addr_ff <= 30'h0;
      size_ff <= IFBM_SIZE_8W;
      cache_ff <= 1'b0;
      user_ff <= 1'b0;
      touch_ff <= 1'b0;
      prio_ff <= IFBM_PRIO_RST;
      prio_cfg_ff <= IFBM_PRIO_RST;
      taken_ff <= 1'b0;
      dropped_ff <= 1'b0;
    end
    else
    begin
      st_ff <= nxt_st;
      req_ff <= nxt_req;
      abort_ff <= nxt_abort;
      addr_ff <= nxt_addr;
      size_ff <= nxt_size;
      cache_ff <= nxt_cache;
      user_ff <= nxt_user;
      touch_ff <= nxt_touch;
      prio_ff <= nxt_prio;
      prio_cfg_ff <= fetch_priority_bits;
      taken_ff <= nxt_taken;
      dropped_ff <= nxt_dropped;
    end
  end

  // ---------------------------------------------------------------
  // Outstanding requests and fill buffer
  // ---------------------------------------------------------------
  ifbm_req_track u_trk
  (
    .clk_sys(clk_sys),
    .rst_n(rst_n),
    .push(push),
    .push_ent(push_ent),
    .rd_data_ack(rd_data_ack),
    .rd_word_index(rd_word_index),
    .rd_data(rd_data),
    .pend_cnt(pend_cnt),
    .done(trk_done),
    .bt(bt.trk)
  );

  ifbm_fill_buf u_fbuf
  (
    .clk_sys(clk_sys),
    .rst_n(rst_n),
    .bt(bt.fbuf),
    .fetch_no_allocate(fetch_no_allocate),
    .lookup_addr(lookup_addr),
    .lookup_hit_ff(lookup_hit),
    .lookup_word_ff(lookup_word),
    .cache_wr_ff(cache_wr),
    .cache_wr_line_ff(cache_wr_line),
    .cache_wr_data_ff(cache_wr_data)
  );

  assign fetch_req = req_ff;
  assign fetch_abort = abort_ff;
  assign fetch_addr = addr_ff;
  assign line_size = size_ff;
  assign cacheable_attr = cache_ff;
  assign user_attr = user_ff;
  assign req_priority = prio_ff;
  assign cpu_req_taken = taken_ff;
  assign cpu_req_dropped = dropped_ff;

  // ---------------------------------------------------------------
  // Checks
  // ---------------------------------------------------------------
  property p_req_drop;
    @(posedge clk_sys) disable iff (!rst_n)
    fetch_req && addr_ack |=> !fetch_req;
  endproperty
  a_req_drop: assert property (p_req_drop)
    else $error("request not dropped after acknowledge");

  property p_abort_drop;
    @(posedge clk_sys) disable iff (!rst_n)
    fetch_abort |-> fetch_req ##1 !fetch_req;
  endproperty
  a_abort_drop: assert property (p_abort_drop)
    else $error("abort without request or request not dropped");

  property p_hold_attr;
    @(posedge clk_sys) disable iff (!rst_n)
    fetch_req ##1 fetch_req |-> $stable(fetch_addr) &&
      $stable(line_size) && $stable(cacheable_attr) &&
      $stable(user_attr) && $stable(req_priority);
  endproperty
  a_hold_attr: assert property (p_hold_attr)
    else $error("request attributes changed while requesting");

  property p_size_cache;
    @(posedge clk_sys) disable iff (!rst_n)
    fetch_req && cacheable_attr |-> line_size == IFBM_SIZE_8W;
  endproperty
  a_size_cache: assert property (p_size_cache)
    else $error("cacheable fetch not eight words");

  property p_size_enc;
    @(posedge clk_sys) disable iff (!rst_n)
    $rose(fetch_req) |-> line_size ==
      ($past(noncache_req_size) || cacheable_attr ?
       IFBM_SIZE_8W : IFBM_SIZE_4W);
  endproperty
  a_size_enc: assert property (p_size_enc)
    else $error("line size encoding wrong");

  property p_two_max;
    @(posedge clk_sys) disable iff (!rst_n)
    $rose(fetch_req) |-> pend_cnt < IFBM_PEND_MAX;
  endproperty
  a_two_max: assert property (p_two_max)
    else $error("third request while two outstanding");

  property p_third_gap;
    @(posedge clk_sys) disable iff (!rst_n)
    trk_done && pend_cnt == IFBM_PEND_MAX |-> !fetch_req ##1 !fetch_req;
  endproperty
  a_third_gap: assert property (p_third_gap)
    else $error("third request too soon after completion");

  property p_prio;
    @(posedge clk_sys) disable iff (!rst_n)
    $rose(fetch_req) |-> req_priority == $past(prio_cfg_ff);
  endproperty
  a_prio: assert property (p_prio)
    else $error("priority not taken from configuration");
endmodule
`default_nettype wire

// ---- ifbm_slave_model.sv ----
// Slave model: bus slave and arbiter answering the fetch master port
`timescale 1ns/10ps
`default_nettype none
module ifbm_slave_model
(
  input wire logic clk_sys,
  input wire logic rst_n,
  input wire logic fetch_req,
  input wire logic [29:0] fetch_addr,
  input wire logic [1:0] line_size,
  input wire logic fetch_abort,
  input wire logic wide,
  input wire logic [2:0] ack_dly,
  input wire logic stall,
  output logic addr_ack,
  output logic slave_width,
  output logic rd_data_ack,
  output logic [2:0] rd_word_index,
  output logic [63:0] rd_data,
  output logic line_end,
  output int n_open
);
  typedef struct packed
  {
    logic [29:0] a;
    logic eight;
    logic wide;
  } ifbm_sl_s;
  ifbm_sl_s q[$];
  ifbm_sl_s e;
  logic [2:0] wait_ff, st, idx;
  logic [3:0] beat_ff, nb;
  logic [29:0] w;

  function automatic logic [31:0] word_of(input logic [29:0] a);
    return {a, 2'h3} ^ 32'hC3A5_0000;
  endfunction

  // Zero wait answers in the request's first cycle
  assign addr_ack = fetch_req && (wait_ff == ack_dly);
  assign slave_width = addr_ack ? wide : !wide;

  always @(posedge clk_sys or negedge rst_n)
  begin
    if (!rst_n)
    begin
      q.delete();
      wait_ff <= 3'h0;
      beat_ff <= 4'h0;
      rd_data_ack <= 1'b0;
      rd_word_index <= 3'h0;
      rd_data <= 64'h0;
      line_end <= 1'b0;
      n_open <= 0;
    end
    else
    begin
      rd_data_ack <= 1'b0;
      line_end <= 1'b0;
      // Idle read bus keeps changing so stale data never matches
      rd_data <= ~rd_data;
      rd_word_index <= rd_word_index + 3'h1;
      wait_ff <= (fetch_req && !addr_ack) ? wait_ff + 3'h1 : 3'h0;
      if (addr_ack && !fetch_abort)
        q.push_back('{fetch_addr, line_size == 2'h2, wide});
      if (q.size() > 0 && !stall)
      begin
        e = q[0];
        st = e.a[2:0];
        nb = (e.eight ? 4'h8 : 4'h4) >> e.wide;
        // Target word first, wrapping inside the aligned line
        if (e.wide)
          idx = e.eight ? {st[2:1] + beat_ff[1:0], 1'b0}
                        : {st[2], st[1] ^ beat_ff[0], 1'b0};
        else
          idx = e.eight ? st + beat_ff[2:0]
                        : {st[2], st[1:0] + beat_ff[1:0]};
        w = {e.a[29:3], idx};
        rd_data_ack <= 1'b1;
        rd_word_index <= idx;
        rd_data <= e.wide ? {word_of(w), word_of(w | 30'h1)}
                          : {word_of(w), word_of(w)};
        // Whole head line goes out before any word of the next
        if (beat_ff == nb - 4'h1)
        begin
          beat_ff <= 4'h0;
          line_end <= 1'b1;
          void'(q.pop_front());
        end
        else
          beat_ff <= beat_ff + 4'h1;
      end
      n_open <= q.size();
    end
  end
endmodule
`default_nettype wire

// ---- ifbm_port_tb.sv ----
// Testbench: fetch master port against the slave model
`timescale 1ns/10ps
`default_nettype none
module ifbm_port_tb;
  import ifbm_pkg::*;

  // ----------------------------------------
  // Signals
  // ----------------------------------------
  logic clk_sys, rst_n = 1'b0, cpu_req_valid = 1'b0, cpu_req_cancel = 1'b0;
  logic cpu_req_cacheable = 1'b0, cpu_req_user = 1'b0, cpu_req_touch = 1'b0;
  logic noncache_req_size = 1'b0, fetch_no_allocate = 1'b0, pipe_en = 1'b0;
  logic wide = 1'b0, stall = 1'b0, st_en = 1'b0;
  logic [1:0] fetch_priority_bits = 2'h0, e_size, e_prio, req_priority;
  logic [1:0] line_size;
  logic [2:0] ack_dly = 3'h0, rd_word_index;
  logic [29:0] cpu_req_addr = 30'h0, lookup_addr = 30'h0, fetch_addr, e_addr;
  logic addr_ack, slave_width, rd_data_ack, line_end, fetch_req, fetch_abort;
  logic cacheable_attr, user_attr, cpu_req_taken, cpu_req_dropped;
  logic lookup_hit, cache_wr, e_cach, e_user, ca, na, tc, l8;
  logic pr = 1'b0, pa = 1'b0, pab = 1'b0, piped = 1'b0, two = 1'b0;
  logic [63:0] rd_data;
  logic [31:0] lookup_word, r, seed = 32'h0001_3126;
  logic [26:0] cache_wr_line, cw_l;
  logic [255:0] cache_wr_data, cw_d;
  logic [29:0] a;
  int n_open, errors = 0, n_checks = 0, since = 0, cyc = 0, cw_n = 0;
  int tk_n = 0, dr_n = 0, ab_n = 0, le_n = 0, t, k0, k1, k2, k3;

  ifbm_port uut (.*);
  ifbm_slave_model slv (.*);

  initial
  begin
    clk_sys = 1'b0;
    forever #2.5 clk_sys = ~clk_sys;
  end

  // ----------------------------------------
  // Helpers
  // ----------------------------------------
  function automatic logic [31:0] rnd();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction

  function automatic logic [31:0] word_of(input logic [29:0] ad);
    return {ad, 2'h3} ^ 32'hC3A5_0000;
  endfunction

  function automatic logic [255:0] line_of(input logic [29:0] b);
    logic [255:0] v;
    for (int i = 0; i < 8; i++)
      v[255 - 32 * i -: 32] = word_of(b + 30'(i));
    return v;
  endfunction

  task automatic chk(input string nm, input logic [255:0] e,
                     input logic [255:0] g);
    n_checks++;
    if (g !== e)
    begin
      errors++;
      $display("[FAIL] %s exp %0h got %0h", nm, e, g);
    end
  endtask

  task automatic complete_run();
    $display("Checks %0d, mismatches %0d", n_checks, errors);
    if (errors == 0 && n_checks > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask

  task automatic tmo(input string nm);
    errors++;
    $display("[FAIL] %s exp done got timeout", nm);
    complete_run();
  endtask

  task automatic issue(input logic [29:0] ad, input logic cc, uu, tt, kk);
    int i;
    @(posedge clk_sys);
    cpu_req_addr <= ad;
    cpu_req_cacheable <= cc;
    cpu_req_user <= uu;
    cpu_req_touch <= tt;
    cpu_req_cancel <= kk;
    cpu_req_valid <= 1'b1;
    e_addr <= ad;
    e_cach <= cc;
    e_user <= uu;
    e_size <= (cc || noncache_req_size) ? 2'h2 : 2'h1;
    for (i = 0; i < 200; i++)
    begin
      @(posedge clk_sys);
      // Let go at the edge that closes the request, before a re-issue
      if ((fetch_req === 1'b1 && addr_ack === 1'b1) ||
          fetch_abort === 1'b1)
        break;
    end
    if (i == 200)
      tmo("request");
    cpu_req_valid <= 1'b0;
    cpu_req_cancel <= 1'b0;
  endtask

  task automatic drain();
    int i;
    for (i = 0; i < 400; i++)
    begin
      @(posedge clk_sys);
      if (n_open == 0 && fetch_req === 1'b0 && rd_data_ack === 1'b0)
        break;
    end
    if (i == 400)
      tmo("drain");
    repeat (3) @(posedge clk_sys);
  endtask

  // Line words hit, the next line misses, cache write as expected
  task automatic chk_line(input logic [29:0] b, input logic look, expw,
                          input int cw0, nw);
    for (int w = 0; w <= nw && look; w++)
    begin
      @(posedge clk_sys);
      lookup_addr <= b + 30'(w);
      @(posedge clk_sys);
      #1;
      chk("lookup_hit", w < nw, lookup_hit);
      if (w < nw)
        chk("lookup_word", word_of(b + 30'(w)), lookup_word);
    end
    chk("cache_wr", expw, cw_n != cw0);
    if (expw)
    begin
      chk("cache_line", b[29:3], cw_l);
      chk("cache_data", line_of(b), cw_d);
    end
  endtask

  // ----------------------------------------
  // Bus monitor
  // ----------------------------------------
  always @(posedge clk_sys)
  begin
    cyc++;
    stall <= st_en && (cyc % 3 != 0);
    if (rst_n)
    begin
      since = line_end ? 0 : since + 1;
      le_n += int'(line_end);
      tk_n += int'(cpu_req_taken);
      dr_n += int'(cpu_req_dropped);
      ab_n += int'(fetch_abort);
      if (cache_wr)
      begin
        cw_n++;
        cw_l = cache_wr_line;
        cw_d = cache_wr_data;
      end
      if (n_open == 2)
      begin
        two = 1'b1;
        piped = 1'b1;
      end
      if (fetch_req || pa)
      begin
        chk("fetch_addr", e_addr, fetch_addr);
        chk("line_size", e_size, line_size);
        chk("cacheable", e_cach, cacheable_attr);
        chk("user_attr", e_user, user_attr);
        chk("priority", e_prio, req_priority);
      end
      if (pa || pab)
        chk("req_low", 0, fetch_req);
      if (fetch_abort)
        chk("abort_req", 1, fetch_req);
      if (fetch_req && !pr)
      begin
        chk("open_count", 1, n_open < 2);
        if (two)
          chk("third_gap", 1, since >= 2);
        two = 1'b0;
      end
      pr = fetch_req;
      pa = fetch_req && addr_ack;
      pab = fetch_abort;
    end
  end

  // ----------------------------------------
  // Scenarios
  // ----------------------------------------
  initial
  begin
    repeat (12) @(posedge clk_sys);
    #1;
    chk("reset_req", 0, fetch_req);
    chk("reset_abort", 0, fetch_abort);
    chk("reset_prio", 2'h3, req_priority);
    @(posedge clk_sys);
    rst_n <= 1'b1;
    $display("Test reset done");
    for (t = 0; t < 12; t++)
    begin
      r = rnd();
      a = r[29:0];
      ca = (t < 4) ? t[0] : ((t == 4) | r[0]);
      na = (t < 4) ? t[1] : ((t == 4) | r[1]);
      tc = (t < 4) ? 1'b0 : ((t == 4) | r[9]);
      k0 = cw_n;
      k1 = tk_n;
      @(posedge clk_sys);
      fetch_no_allocate <= na;
      noncache_req_size <= r[2];
      wide <= r[3];
      ack_dly <= (t == 0) ? 3'h0 : {1'b0, r[5:4]};
      fetch_priority_bits <= r[7:6];
      e_prio <= r[7:6];
      st_en <= r[10];
      issue(a, ca, r[8], tc, 1'b0);
      drain();
      chk("taken", k1 + 1, tk_n);
      l8 = ca || r[2];
      chk_line(l8 ? {a[29:3], 3'h0} : {a[29:2], 2'h0}, 1'b1,
               ca && (!na || tc), k0, l8 ? 8 : 4);
    end
    $display("Test random fetch done");
    for (t = 1; t < 5; t += 3)
    begin
      @(posedge clk_sys);
      ack_dly <= 3'(t);
      k0 = tk_n;
      k1 = dr_n;
      k2 = ab_n;
      k3 = le_n;
      issue(30'h0000_1000 + 30'(t * 8), 1'b1, 1'b0, 1'b0, 1'b1);
      drain();
      chk("taken", k0, tk_n);
      chk("dropped", k1 + 1, dr_n);
      chk("aborts", k2 + 1, ab_n);
      chk("lines", k3, le_n);
    end
    $display("Test abort done");
    @(posedge clk_sys);
    pipe_en <= 1'b1;
    // One wait state so that an abort can meet the acknowledge
    ack_dly <= 3'h1;
    wide <= 1'b0;
    st_en <= 1'b1;
    fetch_no_allocate <= 1'b0;
    r = rnd();
    a = {r[29:8], 8'h00};
    k0 = cw_n;
    k1 = dr_n;
    k3 = le_n;
    issue(a, 1'b1, 1'b0, 1'b0, 1'b0);
    issue(a + 30'h8, 1'b1, 1'b0, 1'b0, 1'b1);
    issue(a + 30'h8, 1'b1, 1'b1, 1'b0, 1'b0);
    issue(a + 30'h10, 1'b1, 1'b0, 1'b0, 1'b0);
    drain();
    chk("pipelined", 1, piped);
    chk("pipe_dropped", k1 + 1, dr_n);
    chk("pipe_lines", k3 + 3, le_n);
    chk_line(a + 30'h10, 1'b1, 1'b1, k0 + 2, 8);
    $display("Test pipeline done");
    complete_run();
  end
endmodule
`default_nettype wire
